// ### design/oacr_regs.sv
// stabilization accelerometer config register and x/y user offset registers
// assumes primary and auxiliary register ports are synchronous byte strobes
`timescale 1ns/1ps
`default_nettype none
module oacr_regs #(
	parameter int OFS_SHIFT_LO = 0,
	parameter int OFS_SHIFT_HI = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire oacr_pkg::oacr_req_t pri_req,
	output oacr_pkg::oacr_rsp_t pri_rsp,
	input wire oacr_pkg::oacr_req_t aux_req,
	output oacr_pkg::oacr_rsp_t aux_rsp,
	input wire logic accel_range_source_mode,
	input wire logic [1:0] ui_accel_range,
	input wire logic ui_accel_on,
	input wire logic offset_weight_sel,
	input wire oacr_pkg::oacr_smp_t accel_x_in,
	input wire oacr_pkg::oacr_smp_t accel_y_in,
	input wire oacr_pkg::oacr_smp_t stab_in,
	output oacr_pkg::oacr_smp_t accel_x_out,
	output oacr_pkg::oacr_smp_t accel_y_out,
	output oacr_pkg::oacr_smp_t stab_out,
	output oacr_pkg::oacr_range_t stab_accel_range,
	output logic [2:0] stab_accel_bw_sel,
	output logic selftest_active,
	output logic selftest_negative
);
	import oacr_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] stab_accel_range_sel;
		logic [2:0] stab_accel_bw_sel;
		logic [1:0] stab_gyro_selftest_sel;
		logic selftest_clamp_off;
		logic [7:0] x_offset_value;
		logic [7:0] y_offset_value;
		oacr_rsp_t pri_rsp;
		oacr_rsp_t aux_rsp;
		oacr_range_t eff_range;
		logic st_active;
		logic st_neg;
	} oacr_state_t;

	oacr_state_t state_q, state_d;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic oacr_range_t range_map(input logic src_mode, input logic [1:0] fld,
		input logic ui_on, input logic [1:0] ui_rng);
		oacr_range_t r;
		r = oacr_range_t'(ui_rng);
		if (src_mode) begin
			unique case (fld)
				2'b00: r = OACR_RANGE_2G;
				2'b01: r = ui_on ? OACR_RANGE_2G : OACR_RANGE_16G;
				2'b10: r = OACR_RANGE_4G;
				2'b11: r = OACR_RANGE_8G;
			endcase
		end
		return r;
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input oacr_state_t s,
		input logic src_mode, input logic [1:0] ui_rng);
		logic [7:0] v;
		v = OACR_UNMAPPED_RD;
		unique case (addr)
			OACR_OFS_CONFIG: begin
				v[OACR_RANGE_LSB +: 2] = src_mode ? s.stab_accel_range_sel : ui_rng;
				v[OACR_BW_LSB +: 3] = s.stab_accel_bw_sel;
				v[OACR_ST_LSB +: 2] = s.stab_gyro_selftest_sel;
				v[OACR_CLAMP_BIT] = s.selftest_clamp_off;
			end
			OACR_OFS_XOFF: v = s.x_offset_value;
			OACR_OFS_YOFF: v = s.y_offset_value;
			default: v = OACR_UNMAPPED_RD;
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		// only the auxiliary port may change the config register
		if (aux_req.wr && aux_req.addr == OACR_OFS_CONFIG) begin
			state_d.stab_accel_range_sel = aux_req.wdata[OACR_RANGE_LSB +: 2];
			state_d.stab_accel_bw_sel = aux_req.wdata[OACR_BW_LSB +: 3];
			state_d.stab_gyro_selftest_sel = aux_req.wdata[OACR_ST_LSB +: 2];
			state_d.selftest_clamp_off = aux_req.wdata[OACR_CLAMP_BIT];
		end
		// primary writes to the config offset fall through with no effect
		if (pri_req.wr && pri_req.addr == OACR_OFS_XOFF) begin
			state_d.x_offset_value = pri_req.wdata;
		end
		if (pri_req.wr && pri_req.addr == OACR_OFS_YOFF) begin
			state_d.y_offset_value = pri_req.wdata;
		end
		state_d.pri_rsp.rvalid = pri_req.rd;
		state_d.pri_rsp.rdata = pri_req.rd
			? read_mux(pri_req.addr, state_q, accel_range_source_mode, ui_accel_range)
			: state_q.pri_rsp.rdata;
		state_d.aux_rsp.rvalid = aux_req.rd;
		state_d.aux_rsp.rdata = aux_req.rd
			? read_mux(aux_req.addr, state_q, accel_range_source_mode, ui_accel_range)
			: state_q.aux_rsp.rdata;
		state_d.eff_range = range_map(accel_range_source_mode, state_q.stab_accel_range_sel,
			ui_accel_on, ui_accel_range);
		// codes 01 and 11 enable self-test, bit 1 gives the sign
		state_d.st_active = state_q.stab_gyro_selftest_sel[0];
		state_d.st_neg = state_q.stab_gyro_selftest_sel == OACR_ST_NEG;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
			state_q.stab_accel_range_sel <= OACR_RANGE_RST;
			state_q.stab_accel_bw_sel <= OACR_BW_RST;
			state_q.stab_gyro_selftest_sel <= OACR_ST_RST;
			state_q.selftest_clamp_off <= OACR_CLAMP_RST;
			state_q.x_offset_value <= OACR_OFF_RST;
			state_q.y_offset_value <= OACR_OFF_RST;
			state_q.eff_range <= OACR_RANGE_2G;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// data paths
	// ----------------------------------------------------------------
	oacr_offset_sub #(
		.SHIFT_LO(OFS_SHIFT_LO),
		.SHIFT_HI(OFS_SHIFT_HI)
	) u_x_sub (
		.mclk(mclk),
		.rstn(rstn),
		.smp_in(accel_x_in),
		.offset(state_q.x_offset_value),
		.weight_sel(offset_weight_sel),
		.smp_out(accel_x_out)
	);

	oacr_offset_sub #(
		.SHIFT_LO(OFS_SHIFT_LO),
		.SHIFT_HI(OFS_SHIFT_HI)
	) u_y_sub (
		.mclk(mclk),
		.rstn(rstn),
		.smp_in(accel_y_in),
		.offset(state_q.y_offset_value),
		.weight_sel(offset_weight_sel),
		.smp_out(accel_y_out)
	);

	// the clamp uses the registered self-test decode, one cycle behind the field
	oacr_stab_out u_stab (
		.mclk(mclk),
		.rstn(rstn),
		.smp_in(stab_in),
		.st_active(state_q.st_active),
		.st_neg(state_q.st_neg),
		.clamp_off(state_q.selftest_clamp_off),
		.smp_out(stab_out)
	);

	assign pri_rsp = state_q.pri_rsp;
	assign aux_rsp = state_q.aux_rsp;
	assign stab_accel_range = state_q.eff_range;
	assign stab_accel_bw_sel = state_q.stab_accel_bw_sel;
	assign selftest_active = state_q.st_active;
	assign selftest_negative = state_q.st_neg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	sequence aux_cfg_wr_s;
		aux_req.wr && aux_req.addr == OACR_OFS_CONFIG;
	endsequence

	sequence pri_only_cfg_wr_s;
		pri_req.wr && pri_req.addr == OACR_OFS_CONFIG
			&& !(aux_req.wr && aux_req.addr == OACR_OFS_CONFIG);
	endsequence

	cfg_aux_write_a: assert property (aux_cfg_wr_s |=>
		stab_accel_bw_sel == $past(aux_req.wdata[OACR_BW_LSB +: 3]))
		else $error("aux config write not stored");

	cfg_pri_ignore_a: assert property (pri_only_cfg_wr_s |=>
		$stable(stab_accel_bw_sel) && $stable(state_q.stab_gyro_selftest_sel))
		else $error("primary write altered config");

	range_ui_src_a: assert property (!accel_range_source_mode && $stable(ui_accel_range)
		|=> stab_accel_range == oacr_range_t'($past(ui_accel_range)))
		else $error("ui range not applied");

	range_map16_a: assert property (accel_range_source_mode && !ui_accel_on
		&& state_q.stab_accel_range_sel == 2'b01 |=> stab_accel_range == OACR_RANGE_16G)
		else $error("range 01 with ui off not 16g");

	range_readback_a: assert property (pri_req.rd && pri_req.addr == OACR_OFS_CONFIG
		&& !accel_range_source_mode |=> pri_rsp.rvalid
		&& pri_rsp.rdata[OACR_RANGE_LSB +: 2] == $past(ui_accel_range))
		else $error("ui range not read back");

	st_decode_a: assert property (aux_cfg_wr_s ##1 !aux_req.wr [*2]
		|-> selftest_active == $past(aux_req.wdata[OACR_ST_LSB], 2)
		&& selftest_negative == ($past(aux_req.wdata[OACR_ST_LSB +: 2], 2) == 2'b11))
		else $error("self-test decode wrong");

	clamp_word_a: assert property (stab_in.valid && selftest_active
		&& !state_q.selftest_clamp_off |=> stab_out.valid && stab_out.data == OACR_CLAMP_WORD)
		else $error("clamp word missing");

	st_shift_a: assert property (stab_in.valid && selftest_active && !selftest_negative
		&& state_q.selftest_clamp_off && stab_in.data < 16'h6000
		|=> stab_out.data == $past(stab_in.data) + OACR_ST_SHIFT_LSB)
		else $error("self-test shift wrong");

	st_neg_shift_a: assert property (stab_in.valid && selftest_negative
		&& state_q.selftest_clamp_off && !stab_in.data[15]
		|=> stab_out.data == $past(stab_in.data) - OACR_ST_SHIFT_LSB)
		else $error("negative self-test shift wrong");

	stab_through_a: assert property (stab_in.valid && !selftest_active
		|=> stab_out.valid && stab_out.data == $past(stab_in.data))
		else $error("normal mode sample altered");

	// inputs kept well inside full scale so saturation never masks the correction
	x_corr_a: assert property (accel_x_in.valid && !offset_weight_sel
		&& accel_x_in.data < 16'h4000
		|=> accel_x_out.valid && accel_x_out.data == $past(accel_x_in.data)
		- (16'(signed'($past(state_q.x_offset_value))) <<< OFS_SHIFT_LO))
		else $error("x offset not subtracted");

	y_corr_a: assert property (accel_y_in.valid && !offset_weight_sel
		&& accel_y_in.data < 16'h4000
		|=> accel_y_out.valid && accel_y_out.data == $past(accel_y_in.data)
		- (16'(signed'($past(state_q.y_offset_value))) <<< OFS_SHIFT_LO))
		else $error("y offset sign wrong");

	y_weight_a: assert property (accel_y_in.valid && offset_weight_sel
		&& accel_y_in.data < 16'h4000
		|=> accel_y_out.valid && accel_y_out.data == $past(accel_y_in.data)
		- (16'(signed'($past(state_q.y_offset_value))) <<< OFS_SHIFT_HI))
		else $error("weighted y offset wrong");

	ofs_pri_write_a: assert property (pri_req.wr && pri_req.addr == OACR_OFS_XOFF
		|=> state_q.x_offset_value == $past(pri_req.wdata))
		else $error("x offset write lost");

	ofs_reset_a: assert property ($rose(rstn) |-> state_q.x_offset_value == OACR_OFF_RST
		&& state_q.y_offset_value == OACR_OFF_RST)
		else $error("offsets not zero after reset");

	ofs_y_write_a: assert property (pri_req.wr && pri_req.addr == OACR_OFS_YOFF
		|=> state_q.y_offset_value == $past(pri_req.wdata))
		else $error("y offset write lost");

	pri_read_answer_a: assert property (pri_req.rd |=> pri_rsp.rvalid)
		else $error("primary read not answered");

	aux_read_answer_a: assert property (aux_req.rd |=> aux_rsp.rvalid)
		else $error("auxiliary read not answered");

	range_map_on_a: assert property (accel_range_source_mode && ui_accel_on
		&& state_q.stab_accel_range_sel == 2'b01 |=> stab_accel_range == OACR_RANGE_2G)
		else $error("range 01 with ui on not 2g");

	// range codes equal the field codes for every field value but 01
	range_field_map_a: assert property (accel_range_source_mode
		&& state_q.stab_accel_range_sel != 2'b01
		|=> stab_accel_range == oacr_range_t'($past(state_q.stab_accel_range_sel)))
		else $error("range field not applied");

	cfg_readback_a: assert property (aux_req.rd && aux_req.addr == OACR_OFS_CONFIG
		|=> aux_rsp.rdata[OACR_BW_LSB +: 3] == $past(stab_accel_bw_sel)
		&& aux_rsp.rdata[OACR_ST_LSB +: 2] == $past(state_q.stab_gyro_selftest_sel))
		else $error("config fields not read back");
endmodule
`default_nettype wire

// ### design/oacr_pkg.sv
// shared constants and carriers for the stabilization accel config and offset bank
// assumes one clock domain; register ports are plain strobed byte ports
package oacr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OACR_OFS_CONFIG = 8'h72;
	localparam logic [7:0] OACR_OFS_XOFF = 8'h73;
	localparam logic [7:0] OACR_OFS_YOFF = 8'h74;

	// ----------------------------------------------------------------
	// field positions of ois_accel_config
	// ----------------------------------------------------------------
	localparam int OACR_RANGE_LSB = 6;
	localparam int OACR_BW_LSB = 3;
	localparam int OACR_ST_LSB = 1;
	localparam int OACR_CLAMP_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] OACR_RANGE_RST = 2'h0;
	localparam logic [2:0] OACR_BW_RST = 3'h0;
	localparam logic [1:0] OACR_ST_RST = 2'h0;
	localparam logic OACR_CLAMP_RST = 1'b0;
	localparam logic [7:0] OACR_OFF_RST = 8'h00;
	localparam logic [7:0] OACR_UNMAPPED_RD = 8'h00;

	// ----------------------------------------------------------------
	// output conditioning values
	// ----------------------------------------------------------------
	localparam logic [15:0] OACR_CLAMP_WORD = 16'h8000;
	// nominal shift is one fifth of full scale at every range: 0.2 * 32768
	localparam logic [15:0] OACR_ST_SHIFT_LSB = 16'h199A;

	// range codes as the main accelerometer path encodes them
	typedef enum logic [1:0] {
		OACR_RANGE_2G = 2'b00,
		OACR_RANGE_16G = 2'b01,
		OACR_RANGE_4G = 2'b10,
		OACR_RANGE_8G = 2'b11
	} oacr_range_t;

	typedef enum logic [1:0] {
		OACR_ST_NORMAL0 = 2'b00,
		OACR_ST_POS = 2'b01,
		OACR_ST_NORMAL1 = 2'b10,
		OACR_ST_NEG = 2'b11
	} oacr_st_t;

	// register access request and answer
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} oacr_req_t;

	typedef struct packed {
		logic rvalid;
		logic [7:0] rdata;
	} oacr_rsp_t;

	// a sample with its strobe
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} oacr_smp_t;

endpackage

// ### design/oacr_offset_sub.sv
// one axis of user offset correction: sample minus weighted signed offset
// assumes samples are 16-bit two's complement with a one-cycle valid strobe
`timescale 1ns/1ps
`default_nettype none
module oacr_offset_sub #(
	parameter int SHIFT_LO = 0,
	parameter int SHIFT_HI = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire oacr_pkg::oacr_smp_t smp_in,
	input wire logic [7:0] offset,
	input wire logic weight_sel,
	output oacr_pkg::oacr_smp_t smp_out
);
	import oacr_pkg::*;

	typedef struct packed {
		oacr_smp_t out;
	} oacr_sub_state_t;

	oacr_sub_state_t state_q, state_d;
	logic signed [23:0] ofs_w;
	logic signed [23:0] diff;

	always_comb begin
		state_d = state_q;
		// offset is two's complement; weight picks a left shift
		ofs_w = 24'(signed'(offset));
		ofs_w = weight_sel ? (ofs_w <<< SHIFT_HI) : (ofs_w <<< SHIFT_LO);
		diff = 24'(signed'(smp_in.data)) - ofs_w;
		state_d.out.valid = smp_in.valid;
		if (smp_in.valid) begin
			// saturate rather than wrap near full scale
			if (diff > 24'sd32767) begin
				state_d.out.data = 16'h7FFF;
			end else if (diff < -24'sd32768) begin
				state_d.out.data = 16'h8000;
			end else begin
				state_d.out.data = diff[15:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign smp_out = state_q.out;
endmodule
`default_nettype wire

// ### design/oacr_stab_out.sv
// stabilization output conditioning during gyroscope self-test
// assumes self-test controls are stable registers of the config bank
`timescale 1ns/1ps
`default_nettype none
module oacr_stab_out (
	input wire logic mclk,
	input wire logic rstn,
	input wire oacr_pkg::oacr_smp_t smp_in,
	input wire logic st_active,
	input wire logic st_neg,
	input wire logic clamp_off,
	output oacr_pkg::oacr_smp_t smp_out
);
	import oacr_pkg::*;

	typedef struct packed {
		oacr_smp_t out;
	} oacr_so_state_t;

	oacr_so_state_t state_q, state_d;
	logic signed [17:0] shifted;

	always_comb begin
		state_d = state_q;
		shifted = st_neg ? 18'(signed'(smp_in.data)) - 18'(OACR_ST_SHIFT_LSB)
			: 18'(signed'(smp_in.data)) + 18'(OACR_ST_SHIFT_LSB);
		state_d.out.valid = smp_in.valid;
		if (smp_in.valid) begin
			if (!st_active) begin
				state_d.out.data = smp_in.data;
			end else if (!clamp_off) begin
				state_d.out.data = OACR_CLAMP_WORD;
			end else if (shifted > 18'sd32767) begin
				state_d.out.data = 16'h7FFF;
			end else if (shifted < -18'sd32768) begin
				state_d.out.data = 16'h8000;
			end else begin
				state_d.out.data = shifted[15:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign smp_out = state_q.out;
endmodule
`default_nettype wire

// ### dv/oacr_aux_ctrl.sv
// stabilization controller model on the auxiliary register port
// assumes the bench calls its tasks; one request at a time
`timescale 1ns/1ps
`default_nettype none
module oacr_aux_ctrl (
	input wire logic mclk,
	input wire oacr_pkg::oacr_rsp_t aux_rsp,
	output var oacr_pkg::oacr_req_t aux_req
);
	import oacr_pkg::*;
	initial aux_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
	// released address and data are inverted so a stale value cannot pass for a hold
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		aux_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		aux_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
		@(posedge mclk);
		aux_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		aux_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		v = aux_rsp.rvalid;
		d = aux_rsp.rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the stabilization config and offset bank
// assumes the design samples requests and samples on rising mclk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import oacr_pkg::*;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	oacr_req_t pri_req = '0;
	oacr_rsp_t pri_rsp, aux_rsp;
	oacr_req_t aux_req;
	logic mode = 1'b1;
	logic [1:0] ui_rng = 2'h0;
	logic ui_on = 1'b0;
	logic wsel = 1'b0;
	oacr_smp_t x_in = '0, y_in = '0, s_in = '0, x_out, y_out, s_out;
	oacr_range_t rng;
	logic [2:0] bw;
	logic st_act, st_neg;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [7:0] rb;
	logic v;
	always #5 mclk = ~mclk;
	oacr_regs oacr_regs_inst (.mclk(mclk), .rstn(rstn), .pri_req(pri_req), .pri_rsp(pri_rsp),
		.aux_req(aux_req), .aux_rsp(aux_rsp), .accel_range_source_mode(mode),
		.ui_accel_range(ui_rng), .ui_accel_on(ui_on), .offset_weight_sel(wsel),
		.accel_x_in(x_in), .accel_y_in(y_in), .stab_in(s_in), .accel_x_out(x_out),
		.accel_y_out(y_out), .stab_out(s_out), .stab_accel_range(rng),
		.stab_accel_bw_sel(bw), .selftest_active(st_act), .selftest_negative(st_neg));
	oacr_aux_ctrl oacr_aux_ctrl_inst (.mclk(mclk), .aux_rsp(aux_rsp), .aux_req(aux_req));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic pwr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		pri_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		pri_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic prd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		pri_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		pri_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		chk_bit("pri rvalid", 1'b1, pri_rsp.rvalid);
		d = pri_rsp.rdata;
	endtask
	// one sample on every axis, outputs judged just after the edge that takes them
	task automatic push(input logic [15:0] dx, input logic [15:0] dy, input logic [15:0] ds);
		@(posedge mclk);
		x_in <= '{valid: 1'b1, data: dx};
		y_in <= '{valid: 1'b1, data: dy};
		s_in <= '{valid: 1'b1, data: ds};
		@(posedge mclk);
		x_in <= '{valid: 1'b0, data: ~dx};
		y_in <= '{valid: 1'b0, data: ~dy};
		s_in <= '{valid: 1'b0, data: ~ds};
		#1;
		chk_bit("x valid", 1'b1, x_out.valid);
		chk_bit("y valid", 1'b1, y_out.valid);
		chk_bit("stab valid", 1'b1, s_out.valid);
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		prd(OACR_OFS_CONFIG, rb);
		chk_val("config reset", 16'h0000, {8'h00, rb});
		prd(OACR_OFS_XOFF, rb);
		chk_val("x offset reset", 16'h0000, {8'h00, rb});
		prd(OACR_OFS_YOFF, rb);
		chk_val("y offset reset", 16'h0000, {8'h00, rb});
		prd(8'h5A, rb);
		chk_val("unmapped read", 16'h0000, {8'h00, rb});
		chk_bit("selftest reset", 1'b0, st_act);
	endtask
	task automatic test_access();
		oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, 8'h28);
		pwr(OACR_OFS_CONFIG, 8'hFF);
		cyc(2);
		prd(OACR_OFS_CONFIG, rb);
		chk_val("config after pri write", 16'h0028, {8'h00, rb});
		chk_val("bw after pri write", 16'h0005, {13'h0, bw});
		oacr_aux_ctrl_inst.rd(OACR_OFS_CONFIG, v, rb);
		chk_bit("aux rvalid", 1'b1, v);
		chk_val("config via aux", 16'h0028, {8'h00, rb});
	endtask
	task automatic test_fields();
		logic [1:0] e;
		for (int on = 0; on < 2; on++) begin
			@(posedge mclk);
			ui_on <= on[0];
			for (int c = 0; c < 4; c++) begin
				oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, {c[1:0], 6'h00});
				cyc(2);
				e = (c == 1 && on == 1) ? 2'b00 : c[1:0];
				chk_val("range mode 1", {14'h0, e}, {14'h0, rng});
			end
		end
		for (int b = 0; b < 8; b++) begin
			oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, {2'b00, b[2:0], 3'b000});
			cyc(1);
			chk_val("bw field", {13'h0, b[2:0]}, {13'h0, bw});
		end
	endtask
	task automatic test_ui_range();
		@(posedge mclk);
		mode <= 1'b0;
		oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, 8'hC0);
		for (int u = 0; u < 4; u++) begin
			@(posedge mclk);
			ui_rng <= u[1:0];
			cyc(2);
			chk_val("range mode 0", {14'h0, u[1:0]}, {14'h0, rng});
			prd(OACR_OFS_CONFIG, rb);
			chk_val("range readback", {14'h0, u[1:0]}, {14'h0, rb[7:6]});
		end
		@(posedge mclk);
		mode <= 1'b1;
	endtask
	task automatic test_selftest();
		logic [15:0] e;
		for (int s = 0; s < 4; s++) begin
			for (int k = 0; k < 2; k++) begin
				oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, {5'h00, s[1:0], k[0]});
				cyc(2);
				chk_bit("selftest active", s[0], st_act);
				chk_bit("selftest negative", s == 3, st_neg);
				e = !s[0] ? 16'h1000 : (k == 0) ? 16'h8000 : (s == 3) ? 16'hF666 : 16'h299A;
				push(16'h0000, 16'h0000, 16'h1000);
				chk_val("stab out", e, s_out.data);
			end
		end
		oacr_aux_ctrl_inst.wr(OACR_OFS_CONFIG, 8'h00);
	endtask
	task automatic test_offset();
		oacr_aux_ctrl_inst.wr(OACR_OFS_XOFF, 8'h33);
		pwr(OACR_OFS_XOFF, 8'h81);
		pwr(OACR_OFS_YOFF, 8'h7F);
		prd(OACR_OFS_XOFF, rb);
		chk_val("x offset readback", 16'h0081, {8'h00, rb});
		push(16'h0100, 16'h0000, 16'h1234);
		chk_val("x corrected", 16'h017F, x_out.data);
		chk_val("y corrected", 16'hFF81, y_out.data);
		chk_val("stab passthrough", 16'h1234, s_out.data);
		@(posedge mclk);
		wsel <= 1'b1;
		pwr(OACR_OFS_XOFF, 8'h05);
		push(16'h0100, 16'h0000, 16'h0000);
		chk_val("x weighted", 16'h00B0, x_out.data);
		chk_val("y weighted", 16'hF810, y_out.data);
	endtask
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end
	initial begin
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		test_reset();
		test_access();
		test_fields();
		test_ui_range();
		test_selftest();
		test_offset();
		wrap_up();
	end
endmodule
`default_nettype wire
